// ### dsr_defs.vh
// Register offsets, field positions and reset values of the DMA status block
`ifndef DSR_DEFS_VH
`define DSR_DEFS_VH
`define DSR_ADDR_STATUS      8'h28
`define DSR_ADDR_MASK        8'h2C
`define DSR_ADDR_CTRL        8'h30
`define DSR_ADDR_DESCSTAT    8'h34
`define DSR_STATUS_RESET     32'h0000_0000
`define DSR_MASK_RESET       32'h0000_0000
`define DSR_BIT_TXDONE       0
`define DSR_BIT_TXSTOP       1
`define DSR_BIT_TXNODESC     2
`define DSR_BIT_TXJABBER     3
`define DSR_BIT_TXUNDER      5
`define DSR_BIT_RXDONE       6
`define DSR_BIT_RXNODESC     7
`define DSR_BIT_RXSTOP       8
`define DSR_BIT_RXWDOG       9
`define DSR_BIT_GPTIMER      11
`define DSR_BIT_BUSFAULT     13
`define DSR_BIT_ABNSUM       15
`define DSR_BIT_NRMSUM       16
`define DSR_FLAG_MASK        32'h0000_2BEF
`define DSR_MASK_BITS        32'h0001_ABEF
`define DSR_NORMAL_SRC       32'h0000_0045
`define DSR_ABNORMAL_SRC     32'h0000_2BAA
`define DSR_TX_STOP          3'h0
`define DSR_TX_SUSP          3'h6
`define DSR_RX_STOP          3'h0
`define DSR_RX_SUSP          3'h4
`define DSR_ERRTYPE_PARITY   3'h0
`define DSR_ERRTYPE_MASTER   3'h1
`define DSR_ERRTYPE_TARGET   3'h2
`endif

// ### dsr_dma_status.v
// DMA status register bank with latched flags, summaries, mask and APB slave
`timescale 1ns/1ps
// Contract
// RQ1 - Transmit state reported as read-only three-bit code, no interrupt on change.
// RQ2 - Receive state reported as read-only three-bit code, no interrupt on change.
// RQ3 - Normal summary set when transmit complete, tx descriptor unavailable or rx complete.
// RQ4 - Abnormal summary set when any abnormal flag bit is set.
// RQ5 - Flags latch high until software writes one to that bit.
// RQ6 - Bus fault sets fatal bus error flag and blocks further host bus accesses.
// RQ7 - Software recovers from parity fault with a software reset.
// RQ8 - General timer expiry sets the timer flag.
// RQ9 - Receive watchdog expiry sets the watchdog flag.
// RQ10 - Receive entering stop sets receive stopped flag.
// RQ11 - Unowned receive descriptor sets flag and suspends reception.
// RQ12 - Suspended receive resumes on poll demand with ownership, or new frame.
// RQ13 - Each finished frame reception sets receive complete flag.
// RQ14 - Bus error type codes parity, master, target abort; valid with fatal flag.
// RQ15 - Transmit underflow sets flag, suspends transmit, reports descriptor error.
// RQ16 - Transmit stopped flag set while transmit state is stop.
// RQ17 - Unowned transmit descriptor sets flag and suspends until ownership and poll.
// RQ18 - Reserved bits read zero, writes ignored.
// RQ19 - Writing zero or to state and summary fields changes nothing.
module dsr_dma_status (
   input  wire        core_clk,
   input  wire        rstn,
   input  wire        swReset,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [2:0]  txState,
   input  wire [2:0]  rxState,
   input  wire        txComplete,
   input  wire        txDescUnavail,
   input  wire        txJabber,
   input  wire        txUnderflow,
   input  wire        rxComplete,
   input  wire        rxDescUnavail,
   input  wire        rxWatchdog,
   input  wire        gpTimerExpired,
   input  wire        busFault,
   input  wire [2:0]  busFaultType,
   input  wire        rxPollDemand,
   input  wire        txPollDemand,
   input  wire        rxDescOwned,
   input  wire        txDescOwned,
   input  wire        rxNewFrame,
   output reg         irq,
   output reg         hostBusEnable,
   output reg         rxSuspend,
   output reg         txSuspend,
   output reg         txDescUnderflowErr
);
`include "dsr_defs.vh"

   reg  [31:0] flags_reg;
   reg  [31:0] flags_next;
   reg  [31:0] mask_reg;
   reg  [31:0] mask_next;
   reg  [2:0]  busErrType_reg;
   reg  [2:0]  busErrType_next;
   reg         busBlocked_reg;
   reg         busBlocked_next;
   reg  [2:0]  rxStatePrev_reg;
   reg         rxSuspend_next;
   reg         txSuspend_next;
   reg         txDescErr_next;
   reg         irq_next;
   reg         pready_next;
   reg         pslverr_next;
   reg  [31:0] prdata_next;
   reg  [31:0] setVec;
   reg  [31:0] clrVec;
   reg  [31:0] rdData;
   reg         rdOk;

   wire        access;
   wire        wrAccess;
   wire        takeReq;
   wire [31:0] statusView;

   assign access   = psel & penable;
   assign wrAccess = access & pwrite;
   assign takeReq  = access & ~pready;

   // Readable status word: latched flags, summaries and live state fields
   function [31:0] dsr_status_word;
      input [31:0] f;
      input [2:0]  be;
      input [2:0]  ts;
      input [2:0]  rs;
      begin
         dsr_status_word = f & `DSR_FLAG_MASK; // RQ18
         dsr_status_word[`DSR_BIT_NRMSUM] = |(f & `DSR_NORMAL_SRC); // RQ3
         dsr_status_word[`DSR_BIT_ABNSUM] = |(f & `DSR_ABNORMAL_SRC); // RQ4
         dsr_status_word[25:23] = be; // RQ14
         dsr_status_word[22:20] = ts; // RQ1
         dsr_status_word[19:17] = rs; // RQ2
      end
   endfunction

   function dsr_hit;
      input [7:0] addr;
      input [7:0] target;
      begin
         dsr_hit = (addr == target);
      end
   endfunction

   assign statusView = dsr_status_word(flags_reg, busErrType_reg, txState, rxState);

   // Events gathered into one set vector; txState and rxState feed only the two stop flags
   always @* begin
      setVec = 32'h0000_0000;
      setVec[`DSR_BIT_TXDONE] = txComplete;
      setVec[`DSR_BIT_TXSTOP] = (txState == `DSR_TX_STOP); // RQ16
      setVec[`DSR_BIT_TXNODESC] = txDescUnavail; // RQ17
      setVec[`DSR_BIT_TXJABBER] = txJabber;
      setVec[`DSR_BIT_TXUNDER] = txUnderflow; // RQ15
      setVec[`DSR_BIT_RXDONE] = rxComplete; // RQ13
      setVec[`DSR_BIT_RXNODESC] = rxDescUnavail; // RQ11
      setVec[`DSR_BIT_RXSTOP] = (rxState == `DSR_RX_STOP) &&
                                (rxStatePrev_reg != `DSR_RX_STOP); // RQ10
      setVec[`DSR_BIT_RXWDOG] = rxWatchdog; // RQ9
      setVec[`DSR_BIT_GPTIMER] = gpTimerExpired; // RQ8
      setVec[`DSR_BIT_BUSFAULT] = busFault; // RQ6
   end

   // Set wins over a simultaneous write-one clear so no event is lost
   always @* begin
      clrVec = 32'h0000_0000;
      if (wrAccess && dsr_hit(paddr, `DSR_ADDR_STATUS))
         clrVec = pwdata & `DSR_FLAG_MASK; // RQ19
      flags_next = ((flags_reg & ~clrVec) | setVec) & `DSR_FLAG_MASK; // RQ5
   end

   always @* begin
      mask_next = mask_reg;
      if (takeReq && pwrite && dsr_hit(paddr, `DSR_ADDR_MASK))
         mask_next = pwdata & `DSR_MASK_BITS; // RQ18
   end

   // Error type is kept until reset or the next bus fault so software can still read it later
   always @* begin
      busErrType_next = busErrType_reg;
      busBlocked_next = busBlocked_reg;
      if (busFault) begin
         busErrType_next = busFaultType; // RQ14
         busBlocked_next = 1'b1; // RQ6
      end
   end

   always @* begin
      rxSuspend_next = rxSuspend;
      if (rxDescUnavail)
         rxSuspend_next = 1'b1; // RQ11
      else if ((rxPollDemand && rxDescOwned) || rxNewFrame)
         rxSuspend_next = 1'b0; // RQ12
   end

   always @* begin
      txSuspend_next = txSuspend;
      if (txDescUnavail || txUnderflow)
         txSuspend_next = 1'b1; // RQ17
      else if (txPollDemand && txDescOwned)
         txSuspend_next = 1'b0; // RQ17
   end

   always @* begin
      txDescErr_next = txDescUnderflowErr;
      if (txUnderflow)
         txDescErr_next = 1'b1; // RQ15
      else if (txPollDemand && txDescOwned)
         txDescErr_next = 1'b0;
   end

   // Interrupt follows the flags of the same edge, summaries included
   always @* begin
      irq_next = |(dsr_status_word(flags_next, 3'h0, 3'h0, 3'h0) & mask_reg);
   end

   always @* begin
      rdOk   = 1'b1;
      rdData = 32'h0000_0000;
      case (paddr)
         `DSR_ADDR_STATUS:   rdData = statusView;
         `DSR_ADDR_MASK:     rdData = mask_reg & `DSR_MASK_BITS;
         `DSR_ADDR_CTRL:     rdData = {{31{1'b0}}, busBlocked_reg};
         `DSR_ADDR_DESCSTAT: rdData = {{29{1'b0}}, txDescUnderflowErr, txSuspend, rxSuspend};
         default:            rdOk = 1'b0;
      endcase
   end

   // One wait state: answer in the second cycle after setup with penable high
   always @* begin
      pready_next  = 1'b0;
      pslverr_next = 1'b0;
      prdata_next  = prdata;
      if (takeReq) begin
         pready_next  = 1'b1;
         pslverr_next = ~rdOk;
         prdata_next  = pwrite ? 32'h0000_0000 : rdData;
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         flags_reg <= `DSR_STATUS_RESET;
      end else if (swReset) begin
         flags_reg <= `DSR_STATUS_RESET; // RQ7
      end else begin
         flags_reg <= flags_next; // RQ5
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mask_reg <= `DSR_MASK_RESET;
      end else if (swReset) begin
         mask_reg <= `DSR_MASK_RESET;
      end else begin
         mask_reg <= mask_next;
      end
   end

   // Software reset or rstn low is the only way out of a fatal bus error
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         busErrType_reg <= 3'h0;
         busBlocked_reg <= 1'b0;
      end else if (swReset) begin
         busErrType_reg <= 3'h0;
         busBlocked_reg <= 1'b0; // RQ7
      end else begin
         busErrType_reg <= busErrType_next;
         busBlocked_reg <= busBlocked_next;
      end
   end

   // Fault blocks the host bus in the very next cycle, not one later
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         hostBusEnable <= 1'b1;
      end else if (swReset) begin
         hostBusEnable <= 1'b1;
      end else begin
         hostBusEnable <= ~(busBlocked_reg | busFault); // RQ6
      end
   end

   // Taken from the live state so no false stop edge follows a reset
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rxStatePrev_reg <= 3'h0;
      end else begin
         rxStatePrev_reg <= rxState;
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rxSuspend <= 1'b0;
      end else if (swReset) begin
         rxSuspend <= 1'b0;
      end else begin
         rxSuspend <= rxSuspend_next;
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         txSuspend <= 1'b0;
      end else if (swReset) begin
         txSuspend <= 1'b0;
      end else begin
         txSuspend <= txSuspend_next;
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         txDescUnderflowErr <= 1'b0;
      end else if (swReset) begin
         txDescUnderflowErr <= 1'b0;
      end else begin
         txDescUnderflowErr <= txDescErr_next;
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else if (swReset) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_next;
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (swReset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= pready_next;
         pslverr <= pslverr_next;
         prdata  <= prdata_next;
      end
   end

endmodule

// ### dsr_dma_status_properties.sv
// Port-level assertions for the DMA status register bank
`timescale 1ns/1ps
module dsr_dma_status_properties (
   input wire        core_clk,
   input wire        rstn,
   input wire        swReset,
   input wire        psel,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        rxDescUnavail,
   input wire        txUnderflow,
   input wire        busFault,
   input wire        hostBusEnable,
   input wire        rxSuspend,
   input wire        txSuspend,
   input wire        txDescUnderflowErr
);
   wire statusRead = pready && psel && !pwrite && paddr == 8'h28;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   chk_fault_blocks: assert property (busFault && !swReset |=> !hostBusEnable)
      else $error("bus fault left host access on");
   chk_block_holds: assert property (!hostBusEnable && !swReset |=> !hostBusEnable)
      else $error("host access back without reset");
   chk_rx_suspends: assert property (rxDescUnavail && !swReset |=> rxSuspend)
      else $error("receive not suspended");
   chk_underflow_stop: assert property (txUnderflow && !swReset |=> txSuspend && txDescUnderflowErr)
      else $error("underflow not reported");
   chk_reserved_zero: assert property (statusRead |-> (prdata & 32'hFC00_5410) == 32'h0000_0000)
      else $error("reserved status bit set");
   chk_normal_sum: assert property (statusRead |-> prdata[16] == |(prdata & 32'h0000_0045))
      else $error("normal summary wrong");
   chk_abnormal_sum: assert property (statusRead |-> prdata[15] == |(prdata & 32'h0000_2BAA))
      else $error("abnormal summary wrong");
   chk_unmapped_err: assert property (pready |-> pslverr == !(paddr inside {8'h28, 8'h2C, 8'h30, 8'h34}))
      else $error("error response wrong");
endmodule

// ### dsr_host_model.sv
// Host software model: APB master issuing register transfers
`timescale 1ns/1ps
module dsr_host (
   input  wire        core_clk,
   output reg         psel    = 1'b0,
   output reg         penable = 1'b0,
   output reg         pwrite  = 1'b0,
   output reg  [7:0]  paddr   = 8'h00,
   output reg  [31:0] pwdata  = 32'h0000_0000,
   input  wire [31:0] prdata,
   input  wire        pready
);
   reg [31:0] rdata;
   // Entered just after a rising edge; write-one clears flags
   task xfer(input reg w, input reg [7:0] a, input reg [31:0] d);
      begin
         psel    <= 1'b1;
         pwrite  <= w;
         paddr   <= a;
         pwdata  <= d;
         @(posedge core_clk);
         penable <= 1'b1;
         @(posedge core_clk);
         while (pready !== 1'b1) @(posedge core_clk);
         rdata = prdata;
         psel    <= 1'b0;
         penable <= 1'b0;
         @(posedge core_clk);
      end
   endtask
endmodule

// ### dsr_dma_status_test.sv
// Self-checking bench for the DMA status register bank
`timescale 1ns/1ps
`include "dsr_defs.vh"
module dsr_dma_status_test;
   reg        core_clk = 1'b0;
   reg        rstn = 1'b0, swReset = 1'b0, rxNewFrame = 1'b0;
   reg        rxPollDemand = 1'b0, txPollDemand = 1'b0, rxDescOwned = 1'b0, txDescOwned = 1'b0;
   reg [2:0]  txState = 3'h1, rxState = 3'h1;
   reg [13:0] ev = 14'h0000;
   reg [2:0]  faultType = 3'h1, betExp = 3'h0;
   wire       psel, penable, pwrite, pready, pslverr, irq, hostBusEnable;
   wire       rxSuspend, txSuspend, txDescUnderflowErr;
   wire [7:0] paddr;
   wire [31:0] pwdata, prdata;
   integer    failures = 0, total_checks = 0, i;
   dsr_host host (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));
   dsr_dma_status DUT (.core_clk(core_clk), .rstn(rstn), .swReset(swReset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .txState(txState), .rxState(rxState),
      .txComplete(ev[0]), .txDescUnavail(ev[2]), .txJabber(ev[3]), .txUnderflow(ev[5]),
      .rxComplete(ev[6]), .rxDescUnavail(ev[7]), .rxWatchdog(ev[9]),
      .gpTimerExpired(ev[11]), .busFault(ev[13]), .busFaultType(faultType),
      .rxPollDemand(rxPollDemand), .txPollDemand(txPollDemand), .rxDescOwned(rxDescOwned),
      .txDescOwned(txDescOwned), .rxNewFrame(rxNewFrame), .irq(irq),
      .hostBusEnable(hostBusEnable), .rxSuspend(rxSuspend), .txSuspend(txSuspend),
      .txDescUnderflowErr(txDescUnderflowErr));
   function [31:0] expect_status(input [31:0] f);
      expect_status = f | {6'h00, betExp, txState, rxState,
         |(f & 32'h0000_0045), |(f & 32'h0000_2BAA), 15'h0000};
   endfunction
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
         end
      end
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         host.xfer(1'b0, a, 32'h0000_0000);
         chk(host.rdata, e);
      end
   endtask
   task wrap_up;
      begin
         if (failures == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   initial forever #12.5 core_clk = ~core_clk;
   initial begin
      #(25 * 6000);
      failures = failures + 1;
      wrap_up;
   end
   initial begin
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      rd(`DSR_ADDR_STATUS, expect_status(32'h0000_0000));
      host.xfer(1'b1, `DSR_ADDR_MASK, 32'hFFFF_FFFF);
      rd(`DSR_ADDR_MASK, 32'h0001_ABEF);
      for (i = 0; i < 14; i = i + 1) begin
         if ((`DSR_FLAG_MASK >> i) & 1) begin
            ev[i] <= 1'b1;
            if (i == 13) betExp = faultType;
            txState <= (i == 1) ? 3'h0 : 3'h1;
            rxState <= (i == 8) ? 3'h0 : 3'h1;
            @(posedge core_clk);
            ev <= 14'h0000;
            txState <= 3'h1;
            rxState <= 3'h1;
            @(posedge core_clk);
            rd(`DSR_ADDR_STATUS, expect_status(32'h0000_0001 << i));
            chk(irq, 1'b1);
            host.xfer(1'b1, `DSR_ADDR_STATUS, 32'hFFFF_D410);
            rd(`DSR_ADDR_STATUS, expect_status(32'h0000_0001 << i));
            host.xfer(1'b1, `DSR_ADDR_STATUS, 32'h0000_0001 << i);
            rd(`DSR_ADDR_MASK, 32'h0001_ABEF);
            chk(irq, 1'b0);
         end
      end
      txState <= 3'h6;
      rxState <= 3'h4;
      @(posedge core_clk);
      rd(`DSR_ADDR_STATUS, expect_status(32'h0000_0000));
      chk(irq, 1'b0);
      chk(rxSuspend, 1'b1);
      chk(txDescUnderflowErr, 1'b1);
      rxDescOwned <= 1'b1;
      txDescOwned <= 1'b1;
      rxPollDemand <= 1'b1;
      txPollDemand <= 1'b1;
      @(posedge core_clk);
      rxPollDemand <= 1'b0;
      txPollDemand <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(rxSuspend, 1'b0);
      chk(txSuspend, 1'b0);
      chk(hostBusEnable, 1'b0);
      swReset <= 1'b1;
      betExp = 3'h0;
      @(posedge core_clk);
      swReset <= 1'b0;
      @(posedge core_clk);
      chk(hostBusEnable, 1'b1);
      rd(`DSR_ADDR_STATUS, expect_status(32'h0000_0000));
      rd(8'h3C, 32'h0000_0000);
      wrap_up;
   end
endmodule
bind dsr_dma_status dsr_dma_status_properties chk (.core_clk(core_clk), .rstn(rstn),
   .swReset(swReset), .psel(psel), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .rxDescUnavail(rxDescUnavail),
   .txUnderflow(txUnderflow), .busFault(busFault), .hostBusEnable(hostBusEnable),
   .rxSuspend(rxSuspend), .txSuspend(txSuspend), .txDescUnderflowErr(txDescUnderflowErr));
